// ---- rtl/tmcmp_core.sv ----
// Module: 8-bit timer with two compare channels and waveform outputs
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module tmcmp_core (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_tick,
  input  wire logic [2:0] irq_ack,
  output logic      [2:0] irq_req,
  output logic      [1:0] wave_pin_o,
  output logic      [1:0] wave_pin_oe_n
);
  // ********************************************
  // Control registers
  // ********************************************
  logic [1:0] out_action_sel_a_q;
  logic [1:0] out_action_sel_b_q;
  logic [2:0] wave_mode_sel_q;
  logic [2:0] clk_source_sel_q;
  logic [2:0] irq_mask_q;
  logic [1:0] port_val_q;
  logic [1:0] wave_pin_dir_q;
  logic [7:0] count_value_q;
  logic [7:0] compare_value_a_q;
  logic [7:0] compare_value_b_q;
  logic [7:0] cmp_buf_a_q;
  logic [7:0] cmp_buf_b_q;
  logic [2:0] flags_q;
  logic [1:0] wave_out_state_q;
  logic       count_up_q;
  logic       block_q;
  logic [2:0] tick_sync_q;
  logic       ext_lvl_q;
  logic [7:0] rdata_q;

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == tmcmp_pkg::MODE_PC_MAX) || (m == tmcmp_pkg::MODE_FP_MAX) ||
             (m == tmcmp_pkg::MODE_PC_A) || (m == tmcmp_pkg::MODE_FP_A);
  endfunction

  function automatic logic [1:0] act_result(input logic [1:0] act,
                                            input logic       cur);
    case (act)
      tmcmp_pkg::ACT_TOGGLE: act_result = {1'b1, ~cur};
      tmcmp_pkg::ACT_CLEAR:  act_result = {1'b1, 1'b0};
      tmcmp_pkg::ACT_SET:    act_result = {1'b1, 1'b1};
      default:               act_result = {1'b0, cur};
    endcase
  endfunction

  // One-cycle write strobe aimed at one register index
  function automatic logic wr_hit(input logic       stb,
                                  input logic [3:0] addr,
                                  input logic [3:0] want);
    wr_hit = stb && (addr == want);
  endfunction

  logic wr_ctrl_a;
  logic wr_mask;
  logic wr_pin;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_flags;
  logic pwm_mode;
  logic fast_mode;
  logic dual_mode;
  logic top_is_a;
  logic ext_rise;
  logic tick;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;
  logic [1:0] match;
  logic [1:0] force_hit;

  assign wr_ctrl_a = wr_hit(reg_wr, reg_addr, tmcmp_pkg::ADDR_CTRL_A);
  assign wr_ctrl_b = wr_hit(reg_wr, reg_addr, tmcmp_pkg::ADDR_CTRL_B);
  assign wr_count  = wr_hit(reg_wr, reg_addr, tmcmp_pkg::ADDR_COUNT);
  assign wr_flags  = wr_hit(reg_wr, reg_addr, tmcmp_pkg::ADDR_FLAGS);
  assign wr_mask   = wr_hit(reg_wr, reg_addr, tmcmp_pkg::ADDR_IRQ_MASK);
  assign wr_pin    = wr_hit(reg_wr, reg_addr, tmcmp_pkg::ADDR_PIN_CTRL);
  assign pwm_mode  = is_pwm(wave_mode_sel_q);
  assign fast_mode = (wave_mode_sel_q == tmcmp_pkg::MODE_FP_MAX) ||
                     (wave_mode_sel_q == tmcmp_pkg::MODE_FP_A);
  assign dual_mode = pwm_mode && !fast_mode;
  assign top_is_a  = (wave_mode_sel_q == tmcmp_pkg::MODE_CLEAR) ||
                     (wave_mode_sel_q == tmcmp_pkg::MODE_PC_A) ||
                     (wave_mode_sel_q == tmcmp_pkg::MODE_FP_A);
  assign top_val   = top_is_a ? compare_value_a_q : tmcmp_pkg::CNT_MAX;
  assign at_top    = (count_value_q == top_val);
  assign at_bottom = (count_value_q == tmcmp_pkg::CNT_BOTTOM);

  // ********************************************
  // Timer tick
  // ********************************************
  // External source passes three stages before it is trusted
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_sync_q <= 3'h0;
    end else begin
      tick_sync_q <= {tick_sync_q[1:0], ext_tick};
    end
  end
  // Level taken only once stages two and three agree; filters short glitches
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_lvl_q <= 1'b0;
    end else if (tick_sync_q[1] == tick_sync_q[2]) begin
      ext_lvl_q <= tick_sync_q[2];
    end
  end
  assign ext_rise = tick_sync_q[1] && tick_sync_q[2] && !ext_lvl_q;

  // Prescaler is outside; nonzero other than direct means external rising edge
  always_comb begin
    case (clk_source_sel_q)
      tmcmp_pkg::CLK_STOP:   tick = 1'b0;
      tmcmp_pkg::CLK_DIRECT: tick = 1'b1;
      default:               tick = ext_rise;
    endcase
  end

  // ********************************************
  // Comparator
  // ********************************************
  assign match[0] = (count_value_q == compare_value_a_q) && !block_q;
  assign match[1] = (count_value_q == compare_value_b_q) && !block_q;

  // Blocking lasts until the next tick, even with the clock stopped
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // ********************************************
  // Counter
  // ********************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_value_q <= tmcmp_pkg::CNT_BOTTOM;
      count_up_q    <= 1'b1;
    end else if (wr_count) begin
      count_value_q <= reg_wdata;
    end else if (tick) begin
      if (dual_mode) begin
        if (count_up_q && at_top) begin
          count_up_q    <= 1'b0;
          count_value_q <= count_value_q - 8'h01;
        end else if (!count_up_q && at_bottom) begin
          count_up_q    <= 1'b1;
          count_value_q <= count_value_q + 8'h01;
        end else begin
          count_value_q <= count_up_q ? count_value_q + 8'h01 : count_value_q - 8'h01;
        end
      end else if (top_is_a && at_top) begin
        count_up_q    <= 1'b1;
        count_value_q <= tmcmp_pkg::CNT_BOTTOM;
      end else begin
        count_up_q    <= 1'b1;
        count_value_q <= count_value_q + 8'h01;
      end
    end
  end

  // ********************************************
  // Compare registers
  // ********************************************
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
      logic [3:0] addr_c;
      logic       wr_c;
      logic       load_c;
      logic [7:0] buf_c;
      assign addr_c = (ch == 0) ? tmcmp_pkg::ADDR_CMP_A : tmcmp_pkg::ADDR_CMP_B;
      assign wr_c   = wr_hit(reg_wr, reg_addr, addr_c);
      assign buf_c  = (ch == 0) ? cmp_buf_a_q : cmp_buf_b_q;
      // Fast modes load at top, dual-slope at top; both avoid odd pulses
      assign load_c = tick && (fast_mode ? at_top : (count_up_q && at_top));
      if (ch == 0) begin : g_a
        always_ff @(posedge mclk or negedge arst_n) begin
          if (!arst_n) begin
            compare_value_a_q <= tmcmp_pkg::RST_BYTE;
            cmp_buf_a_q       <= tmcmp_pkg::RST_BYTE;
          end else begin
            if (wr_c) begin
              cmp_buf_a_q <= reg_wdata;
            end
            if (wr_c && !pwm_mode) begin
              compare_value_a_q <= reg_wdata;
            end else if (pwm_mode && load_c) begin
              compare_value_a_q <= buf_c;
            end
          end
        end
      end else begin : g_b
        always_ff @(posedge mclk or negedge arst_n) begin
          if (!arst_n) begin
            compare_value_b_q <= tmcmp_pkg::RST_BYTE;
            cmp_buf_b_q       <= tmcmp_pkg::RST_BYTE;
          end else begin
            if (wr_c) begin
              cmp_buf_b_q <= reg_wdata;
            end
            if (wr_c && !pwm_mode) begin
              compare_value_b_q <= reg_wdata;
            end else if (pwm_mode && load_c) begin
              compare_value_b_q <= buf_c;
            end
          end
        end
      end
    end
  endgenerate

  // ********************************************
  // Control and pin registers
  // ********************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_action_sel_a_q <= tmcmp_pkg::ACT_NONE;
      out_action_sel_b_q <= tmcmp_pkg::ACT_NONE;
      wave_mode_sel_q    <= tmcmp_pkg::MODE_NORMAL;
      clk_source_sel_q   <= tmcmp_pkg::CLK_STOP;
      irq_mask_q         <= 3'h0;
      port_val_q         <= 2'h0;
      wave_pin_dir_q     <= 2'h0;
    end else begin
      if (wr_ctrl_a) begin
        out_action_sel_a_q <= reg_wdata[tmcmp_pkg::ACT_A_POS +: 2];
        out_action_sel_b_q <= reg_wdata[tmcmp_pkg::ACT_B_POS +: 2];
        wave_mode_sel_q[1:0] <= reg_wdata[tmcmp_pkg::MODE_LO_POS +: 2];
      end
      if (wr_ctrl_b) begin
        wave_mode_sel_q[2] <= reg_wdata[tmcmp_pkg::MODE_HI_POS];
        clk_source_sel_q   <= reg_wdata[tmcmp_pkg::CLK_SRC_POS +: 3];
      end
      if (wr_mask) begin
        irq_mask_q <= reg_wdata[2:0];
      end
      if (wr_pin) begin
        port_val_q     <= {reg_wdata[tmcmp_pkg::PORT_B_POS], reg_wdata[tmcmp_pkg::PORT_A_POS]};
        wave_pin_dir_q <= {reg_wdata[tmcmp_pkg::DIR_B_POS], reg_wdata[tmcmp_pkg::DIR_A_POS]};
      end
    end
  end

  // ********************************************
  // Flags
  // ********************************************
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  assign flag_set[tmcmp_pkg::FLG_OVF_POS] = tick && !wr_count && !dual_mode &&
                                            (count_value_q == tmcmp_pkg::CNT_MAX) &&
                                            !(top_is_a && at_top);
  assign flag_set[tmcmp_pkg::FLG_A_POS] = tick && match[0];
  assign flag_set[tmcmp_pkg::FLG_B_POS] = tick && match[1];
  assign flag_clr = (wr_flags ? reg_wdata[2:0] : 3'h0) | irq_ack;

  // Set beats a same-cycle clear so no event is lost
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end
  assign irq_req = flags_q & irq_mask_q;

  // ********************************************
  // Waveform output
  // ********************************************
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_wave
      logic [1:0] act_c;
      logic       hit_c;
      logic       frc_c;
      logic [1:0] res_c;
      logic       pwm_val_c;
      assign act_c = (ch == 0) ? out_action_sel_a_q : out_action_sel_b_q;
      assign frc_c = wr_ctrl_b && !pwm_mode &&
                     reg_wdata[(ch == 0) ? tmcmp_pkg::FORCE_A_POS : tmcmp_pkg::FORCE_B_POS];
      assign force_hit[ch] = frc_c;
      assign hit_c = tick && match[ch];
      assign res_c = act_result(act_c, wave_out_state_q[ch]);
      // Non-inverting clears on up match, sets on down match or at top in fast modes
      assign pwm_val_c = (act_c == tmcmp_pkg::ACT_SET) ^
                         (fast_mode ? 1'b0 : !count_up_q);
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          wave_out_state_q[ch] <= 1'b0;
        end else if (pwm_mode && act_c[1]) begin
          if (hit_c) begin
            wave_out_state_q[ch] <= pwm_val_c;
          end else if (fast_mode && tick && at_top) begin
            wave_out_state_q[ch] <= !(act_c == tmcmp_pkg::ACT_SET);
          end
        end else if ((hit_c || force_hit[ch]) && res_c[1]) begin
          wave_out_state_q[ch] <= res_c[0];
        end
      end
      assign wave_pin_o[ch] = (act_c != tmcmp_pkg::ACT_NONE) ?
                              wave_out_state_q[ch] : port_val_q[ch];
      assign wave_pin_oe_n[ch] = !wave_pin_dir_q[ch];
    end
  endgenerate

  // ********************************************
  // Read port
  // ********************************************
  // Idle cycles read zero so stale data never lingers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        tmcmp_pkg::ADDR_CTRL_A:   rdata_q <= {out_action_sel_a_q, out_action_sel_b_q,
                                              2'h0, wave_mode_sel_q[1:0]};
        tmcmp_pkg::ADDR_CTRL_B:   rdata_q <= {4'h0, wave_mode_sel_q[2], clk_source_sel_q};
        tmcmp_pkg::ADDR_COUNT:    rdata_q <= count_value_q;
        tmcmp_pkg::ADDR_CMP_A:    rdata_q <= pwm_mode ? cmp_buf_a_q : compare_value_a_q;
        tmcmp_pkg::ADDR_CMP_B:    rdata_q <= pwm_mode ? cmp_buf_b_q : compare_value_b_q;
        tmcmp_pkg::ADDR_IRQ_MASK: rdata_q <= {5'h00, irq_mask_q};
        tmcmp_pkg::ADDR_FLAGS:    rdata_q <= {5'h00, flags_q};
        tmcmp_pkg::ADDR_PIN_CTRL: rdata_q <= {4'h0, wave_pin_dir_q, port_val_q};
        default:                  rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ---- rtl/tmcmp_pkg.sv ----
// Package: constants for the 8-bit timer compare and PWM block
package tmcmp_pkg;
  // ********************************************
  // Register offsets
  // ********************************************
  localparam logic [3:0] ADDR_CTRL_A   = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B   = 4'h1;
  localparam logic [3:0] ADDR_COUNT    = 4'h2;
  localparam logic [3:0] ADDR_CMP_A    = 4'h3;
  localparam logic [3:0] ADDR_CMP_B    = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_FLAGS    = 4'h6;
  localparam logic [3:0] ADDR_PIN_CTRL = 4'h7;
  // ********************************************
  // Field positions
  // ********************************************
  // CTRL_A: [7:6] action A, [5:4] action B, [1:0] mode low bits
  localparam int ACT_A_POS  = 6;
  localparam int ACT_B_POS  = 4;
  localparam int MODE_LO_POS = 0;
  // CTRL_B: [7] force A, [6] force B, [3] mode high bit, [2:0] clock source
  localparam int FORCE_A_POS = 7;
  localparam int FORCE_B_POS = 6;
  localparam int MODE_HI_POS = 3;
  localparam int CLK_SRC_POS = 0;
  // FLAGS and IRQ_MASK: [2] match B, [1] match A, [0] overflow
  localparam int FLG_OVF_POS = 0;
  localparam int FLG_A_POS   = 1;
  localparam int FLG_B_POS   = 2;
  // PIN_CTRL: [3] dir B, [2] dir A, [1] port B, [0] port A
  localparam int PORT_A_POS = 0;
  localparam int PORT_B_POS = 1;
  localparam int DIR_A_POS  = 2;
  localparam int DIR_B_POS  = 3;
  // ********************************************
  // Values
  // ********************************************
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_MAX = 3'h1;
  localparam logic [2:0] MODE_CLEAR  = 3'h2;
  localparam logic [2:0] MODE_FP_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_A   = 3'h5;
  localparam logic [2:0] MODE_FP_A   = 3'h7;
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  localparam logic [2:0] CLK_STOP   = 3'h0;
  localparam logic [2:0] CLK_DIRECT = 3'h1;
endpackage

// ---- tb/tmcmp_core_asserts.sv ----
// Checker: port-level assertions for the timer compare block
`timescale 1ns/1ns
`default_nettype none
module tmcmp_chk (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ext_tick,
  input wire logic [2:0] irq_ack,
  input wire logic [2:0] irq_req,
  input wire logic [1:0] wave_pin_o,
  input wire logic [1:0] wave_pin_oe_n
);
  // ********************************************
  // Mirrors of control fields
  // ********************************************
  logic [2:0] src_q;
  logic [1:0] mlo_q;
  logic       mhi_q;
  logic [1:0] act_a_q;
  logic [1:0] act_b_q;
  logic [1:0] port_q;
  logic       stop;
  logic       fwr;
  logic       cwr;
  logic       pwr;
  logic       mwr;
  // Stopped clock: nothing can set a flag, so flags move only by clears
  assign stop = src_q == tmcmp_pkg::CLK_STOP;
  assign fwr  = reg_wr && reg_addr == tmcmp_pkg::ADDR_FLAGS;
  assign cwr  = reg_wr && reg_addr == tmcmp_pkg::ADDR_CTRL_B;
  assign pwr  = reg_wr && reg_addr == tmcmp_pkg::ADDR_PIN_CTRL;
  assign mwr  = reg_wr && reg_addr == tmcmp_pkg::ADDR_IRQ_MASK;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      act_a_q <= 2'h0;
      act_b_q <= 2'h0;
      mlo_q   <= 2'h0;
    end else if (reg_wr && reg_addr == tmcmp_pkg::ADDR_CTRL_A) begin
      act_a_q <= reg_wdata[7:6];
      act_b_q <= reg_wdata[5:4];
      mlo_q   <= reg_wdata[1:0];
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      src_q <= 3'h0;
      mhi_q <= 1'b0;
    end else if (cwr) begin
      src_q <= reg_wdata[2:0];
      mhi_q <= reg_wdata[tmcmp_pkg::MODE_HI_POS];
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      port_q <= 2'h0;
    end else if (pwr) begin
      port_q <= reg_wdata[1:0];
    end
  end
  // ********************************************
  // Properties
  // ********************************************
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence force_a_s;
    cwr && reg_wdata[tmcmp_pkg::FORCE_A_POS] && !reg_wdata[tmcmp_pkg::MODE_HI_POS];
  endsequence
  sequence quiet_set_s;
    stop && !mhi_q && !mlo_q[0] && act_a_q[1];
  endsequence
  force_set_a: assert property (
    force_a_s and quiet_set_s |=> wave_pin_o[0] == $past(act_a_q[0]))
    else $error("forced output level wrong");
  dir_pin_a: assert property (pwr |=> wave_pin_oe_n == ~$past({reg_wdata[3], reg_wdata[2]}))
    else $error("pin enable not from direction bits");
  pin_hold_a: assert property (!pwr |=> $stable(wave_pin_oe_n))
    else $error("pin enable moved without write");
  port_pass_a: assert property (
    (act_a_q != 2'h0 || wave_pin_o[0] == port_q[0]) &&
    (act_b_q != 2'h0 || wave_pin_o[1] == port_q[1]))
    else $error("pin not showing port bit");
  mask_gate_a: assert property (mwr |=> (irq_req & ~$past(reg_wdata[2:0])) == 3'h0)
    else $error("masked request active");
  ack_clear_a: assert property (stop && |irq_ack |=> (irq_req & $past(irq_ack)) == 3'h0)
    else $error("acknowledge did not clear flag");
  flag_wr_clear_a: assert property (
    stop && fwr |=> (irq_req & $past(reg_wdata[2:0])) == 3'h0)
    else $error("write one did not clear flag");
  flag_keep_a: assert property (stop && !(|irq_ack) && !fwr && !mwr |=> $stable(irq_req))
    else $error("flag changed without cause");
endmodule
bind tmcmp_core tmcmp_chk u_tmcmp_chk (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_tick(ext_tick), .irq_ack(irq_ack), .irq_req(irq_req), .wave_pin_o(wave_pin_o),
  .wave_pin_oe_n(wave_pin_oe_n));
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench: register-driven scenarios for the timer compare block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       mclk;
  logic       arst_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       ext_tick;
  logic [2:0] irq_ack;
  logic [2:0] irq_req;
  logic [1:0] wave_pin_o;
  logic [1:0] wave_pin_oe_n;
  int         n_mismatch;
  int         samples_checked;
  int         cycles;
  logic [1:0] act_tab [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
  logic [7:0] pin_tab [4] = '{8'h03, 8'h00, 8'h03, 8'h00};
  tmcmp_core u_tmcmp_core (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_tick(ext_tick), .irq_ack(irq_ack), .irq_req(irq_req), .wave_pin_o(wave_pin_o),
    .wave_pin_oe_n(wave_pin_oe_n));
  always #5 mclk = ~mclk;
  // ********************************************
  // Bus and check tasks
  // ********************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask
  // Start then stop gives n+2 timer ticks
  task automatic run(input int n);
    wr(tmcmp_pkg::ADDR_CTRL_B, 8'h01);
    repeat (n) @(posedge mclk);
    wr(tmcmp_pkg::ADDR_CTRL_B, 8'h00);
  endtask
  task automatic seen(input logic [7:0] e);
    #1;
    chk("outputs", e, {2'h0, wave_pin_oe_n, 1'b0, irq_req});
  endtask
  task automatic pins(input logic [7:0] e);
    #1;
    chk("pins", e, {4'h0, wave_pin_oe_n, wave_pin_o});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ********************************************
  // Scenarios
  // ********************************************
  initial begin
    mclk = 1'b0; arst_n = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; ext_tick = 1'b0; irq_ack = 3'h0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    wr(tmcmp_pkg::ADDR_IRQ_MASK, 8'h07);
    wr(tmcmp_pkg::ADDR_CMP_A, 8'h03);
    wr(tmcmp_pkg::ADDR_CMP_B, 8'h10);
    wr(tmcmp_pkg::ADDR_CTRL_B, 8'h01);
    repeat (3) @(posedge mclk);
    seen(8'h30);
    @(posedge mclk);
    seen(8'h32);
    wr(tmcmp_pkg::ADDR_COUNT, 8'hfd);
    repeat (2) @(posedge mclk);
    seen(8'h32);
    @(posedge mclk);
    seen(8'h33);
    wr(tmcmp_pkg::ADDR_CTRL_B, 8'h00);
    rd(tmcmp_pkg::ADDR_COUNT, 8'h02);
    rd(tmcmp_pkg::ADDR_COUNT, 8'h02);
    wr(tmcmp_pkg::ADDR_FLAGS, 8'h00);
    rd(tmcmp_pkg::ADDR_FLAGS, 8'h03);
    wr(tmcmp_pkg::ADDR_IRQ_MASK, 8'h01);
    seen(8'h31);
    wr(tmcmp_pkg::ADDR_IRQ_MASK, 8'h07);
    wr(tmcmp_pkg::ADDR_FLAGS, 8'h02);
    rd(tmcmp_pkg::ADDR_FLAGS, 8'h01);
    @(posedge mclk);
    irq_ack <= 3'h1;
    @(posedge mclk);
    irq_ack <= 3'h0;
    rd(tmcmp_pkg::ADDR_FLAGS, 8'h00);
    wr(tmcmp_pkg::ADDR_CMP_A, 8'h05);
    wr(tmcmp_pkg::ADDR_COUNT, 8'h05);
    run(0);
    rd(tmcmp_pkg::ADDR_FLAGS, 8'h00);
    rd(tmcmp_pkg::ADDR_COUNT, 8'h07);
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'h02);
    wr(tmcmp_pkg::ADDR_CMP_A, 8'h02);
    wr(tmcmp_pkg::ADDR_COUNT, 8'h00);
    run(2);
    rd(tmcmp_pkg::ADDR_COUNT, 8'h01);
    rd(tmcmp_pkg::ADDR_FLAGS, 8'h02);
    wr(tmcmp_pkg::ADDR_FLAGS, 8'h07);
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'h03);
    wr(tmcmp_pkg::ADDR_CMP_A, 8'h40);
    rd(tmcmp_pkg::ADDR_CMP_A, 8'h40);
    wr(tmcmp_pkg::ADDR_COUNT, 8'h3e);
    run(1);
    rd(tmcmp_pkg::ADDR_FLAGS, 8'h00);
    wr(tmcmp_pkg::ADDR_COUNT, 8'hfd);
    run(2);
    wr(tmcmp_pkg::ADDR_FLAGS, 8'h07);
    wr(tmcmp_pkg::ADDR_COUNT, 8'h3e);
    run(1);
    rd(tmcmp_pkg::ADDR_FLAGS, 8'h02);
    wr(tmcmp_pkg::ADDR_FLAGS, 8'h07);
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'h00);
    wr(tmcmp_pkg::ADDR_PIN_CTRL, 8'h05);
    pins(8'h09);
    wr(tmcmp_pkg::ADDR_PIN_CTRL, 8'h0c);
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'hf0);
    pins(8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(tmcmp_pkg::ADDR_CTRL_A, {act_tab[i], act_tab[i], 4'h0});
      wr(tmcmp_pkg::ADDR_CTRL_B, 8'hc0);
      pins(pin_tab[i]);
    end
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'h50);
    pins(8'h03);
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'h53);
    pins(8'h03);
    wr(tmcmp_pkg::ADDR_CTRL_B, 8'hc0);
    pins(8'h03);
    rd(tmcmp_pkg::ADDR_FLAGS, 8'h00);
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'h00);
    wr(tmcmp_pkg::ADDR_COUNT, 8'h00);
    wr(tmcmp_pkg::ADDR_CTRL_B, 8'h02);
    repeat (3) begin
      ext_tick <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_tick <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    wr(tmcmp_pkg::ADDR_CTRL_B, 8'h00);
    rd(tmcmp_pkg::ADDR_COUNT, 8'h03);
    rd(4'hf, 8'h00);
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'hf0);
    pins(8'h0c);
    wr(tmcmp_pkg::ADDR_CTRL_B, 8'hc0);
    wr(tmcmp_pkg::ADDR_PIN_CTRL, 8'h0c);
    pins(8'h03);
    wr(tmcmp_pkg::ADDR_CTRL_A, 8'hc3);
    wr(tmcmp_pkg::ADDR_CMP_A, 8'h02);
    wr(tmcmp_pkg::ADDR_COUNT, 8'hfe);
    run(2);
    pins(8'h00);
    run(0);
    pins(8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire
